// ===== flqr_cfg.svh
// Purpose: Constants for the flash lock and query readout controller
// Assumes: 50 MHz clock, x16 flash with asynchronous bus
// Notes:   Offsets are byte addresses on the APB side
`ifndef FLQR_CFG_SVH
`define FLQR_CFG_SVH

// Flash command words
`define FLQR_CMD_CFG_SETUP  8'h60
`define FLQR_CMD_LOCK       8'h01
`define FLQR_CMD_UNLOCK     8'hd0
`define FLQR_CMD_LOCKDOWN   8'h2f
`define FLQR_CMD_READ_CFG   8'h90
`define FLQR_CMD_QUERY      8'h98
`define FLQR_CMD_READ_ARRAY 8'hff

// Query map and block status layout
`define FLQR_QRY_BASE       8'h10
`define FLQR_QRY_CHAR_Q     8'h51
`define FLQR_QRY_CHAR_R     8'h52
`define FLQR_QRY_CHAR_Y     8'h59
`define FLQR_BSTAT_OFFSET   8'h02
`define FLQR_BIT_LOCKED     0
`define FLQR_BIT_LOCKDOWN   1

// Software operation codes in CTRL[2:0]
`define FLQR_OP_LOCK        3'h0
`define FLQR_OP_UNLOCK      3'h1
`define FLQR_OP_LOCKDOWN    3'h2
`define FLQR_OP_RDLOCK      3'h3
`define FLQR_OP_QUERY       3'h4

// APB register offsets
`define FLQR_REG_CTRL       12'h000
`define FLQR_REG_ADDR       12'h004
`define FLQR_REG_STATUS     12'h008
`define FLQR_REG_QDATA      12'h040

// Status bit positions
`define FLQR_ST_BUSY        0
`define FLQR_ST_VERIFY_ERR  1
`define FLQR_ST_UPPER_ERR   2
`define FLQR_ST_QRY_OK      3

// Bus timing
`define FLQR_CLK_NS         20
`define FLQR_T_WP_NS        50
`define FLQR_T_ACC_NS       70
`define FLQR_WP_CYC  ((`FLQR_T_WP_NS + `FLQR_CLK_NS - 1) / `FLQR_CLK_NS)
`define FLQR_ACC_CYC ((`FLQR_T_ACC_NS + `FLQR_CLK_NS - 1) / `FLQR_CLK_NS)

`define FLQR_ADDR_W         22

`endif

// ===== flqr_ctrl.sv
// Purpose: Host controller that locks flash blocks and reads the query table
// Assumes: x16 asynchronous flash, inputs synchronous to i_clk
// Notes:   Software drives it over APB; one operation at a time
`timescale 1ns/1ps
`include "flqr_cfg.svh"

// Overview of operation
// - Config setup 60H first, any address
// - Then 01H, D0H or 2FH in block
// - After 90H, read block word at offset 2 (third word)
// - Finish each sequence with FFh
module flqr_ctrl
  import flqr_pkg::*;
#(
  parameter int QLEN = 11
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  // APB slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [11:0]             i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic                         o_pready,
  output logic      [31:0]             o_prdata,
  output logic                         o_pslverr,
  // Flash pins
  output flqr_pins_s                   o_flash,
  input  wire logic [15:0]             i_fl_dq
);

  localparam int QA = $clog2(QLEN + 1);
  localparam logic [3:0] WP_CYC  = 4'(`FLQR_WP_CYC);
  localparam logic [3:0] ACC_CYC = 4'(`FLQR_ACC_CYC);

  flqr_state_e             state_q;
  logic [2:0]              op_q;
  logic [4:0]              step_q;
  logic [3:0]              tmr_q;
  logic [`FLQR_ADDR_W-1:0] base_q;
  logic [7:0]              bstat_q;
  logic                    verify_err_q;
  logic                    upper_err_q;
  logic                    qry_ok_q;
  logic [QA-1:0]           q_raddr;
  logic [7:0]              q_rdata;
  logic                    q_we;
  logic [QA-1:0]           q_widx;

  logic                    plan_wr;
  logic [`FLQR_ADDR_W-1:0] plan_addr;
  logic [7:0]              plan_data;

  function automatic logic [4:0] seq_first(input logic [2:0] op);
    seq_first = (op == `FLQR_OP_RDLOCK) ? 5'h2 : 5'h0;
  endfunction

  function automatic logic [4:0] seq_last(input logic [2:0] op);
    seq_last = (op == `FLQR_OP_QUERY) ? 5'(QLEN + 1) : 5'h4;
  endfunction

  function automatic logic [7:0] confirm_code(input logic [2:0] op);
    case (op)
      `FLQR_OP_UNLOCK:   confirm_code = `FLQR_CMD_UNLOCK;
      `FLQR_OP_LOCKDOWN: confirm_code = `FLQR_CMD_LOCKDOWN;
      default:           confirm_code = `FLQR_CMD_LOCK;
    endcase
  endfunction

  function automatic logic [7:0] qry_expect(input logic [QA-1:0] idx);
    case (idx)
      QA'(0):  qry_expect = `FLQR_QRY_CHAR_Q;
      QA'(1):  qry_expect = `FLQR_QRY_CHAR_R;
      default: qry_expect = `FLQR_QRY_CHAR_Y;
    endcase
  endfunction

  // Bus cycle for the current step
  always_comb
  begin
    plan_wr   = 1'b1;
    plan_addr = base_q;
    plan_data = `FLQR_CMD_READ_ARRAY;
    if (op_q == `FLQR_OP_QUERY)
    begin
      if (step_q == 5'h0)
      begin
        plan_data = `FLQR_CMD_QUERY;
      end
      else if (step_q <= 5'(QLEN))
      begin
        // Table offsets are word addresses on this x16 part
        plan_wr   = 1'b0;
        plan_addr = `FLQR_ADDR_W'(`FLQR_QRY_BASE) + `FLQR_ADDR_W'(step_q - 5'h1);
      end
      else
      begin
        plan_data = `FLQR_CMD_READ_ARRAY;
      end
    end
    else
    begin
      case (step_q)
        5'h0: plan_data = `FLQR_CMD_CFG_SETUP;
        5'h1: plan_data = confirm_code(op_q);
        5'h2: plan_data = `FLQR_CMD_READ_CFG;
        5'h3:
        begin
          plan_wr   = 1'b0;
          plan_addr = base_q + `FLQR_ADDR_W'(`FLQR_BSTAT_OFFSET);
        end
        default: plan_data = `FLQR_CMD_READ_ARRAY;
      endcase
    end
  end

  // Sequencer and flash pins
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_q <= ST_IDLE;
      step_q  <= 5'h0;
      tmr_q   <= 4'h0;
      o_flash <= '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `FLQR_REG_CTRL
              && i_pwdata[2:0] <= `FLQR_OP_QUERY)
          begin
            step_q  <= seq_first(i_pwdata[2:0]);
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          o_flash.addr  <= plan_addr;
          o_flash.dq    <= {8'h00, plan_data};
          o_flash.dq_oe <= plan_wr;
          o_flash.ce_n  <= 1'b0;
          tmr_q         <= plan_wr ? WP_CYC : ACC_CYC;
          state_q       <= ST_STROBE;
        end
        ST_STROBE:
        begin
          o_flash.we_n <= ~o_flash.dq_oe;
          o_flash.oe_n <= o_flash.dq_oe;
          if (tmr_q == 4'h1)
          begin
            state_q <= ST_RELEASE;
          end
          tmr_q <= tmr_q - 4'h1;
        end
        ST_RELEASE:
        begin
          // Releasing strobes before address keeps hold time on writes
          o_flash.we_n  <= 1'b1;
          o_flash.oe_n  <= 1'b1;
          o_flash.ce_n  <= 1'b1;
          o_flash.dq_oe <= 1'b0;
          if (step_q == seq_last(op_q))
          begin
            state_q <= ST_IDLE;
          end
          else
          begin
            step_q  <= step_q + 5'h1;
            state_q <= ST_SETUP;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Read data is sampled as the strobe ends
  assign q_we   = state_q == ST_RELEASE && !o_flash.oe_n && op_q == `FLQR_OP_QUERY;
  assign q_widx = QA'(step_q - 5'h1);

  // Captured results
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      bstat_q      <= 8'h00;
      verify_err_q <= 1'b0;
      upper_err_q  <= 1'b0;
      qry_ok_q     <= 1'b0;
    end
    else if (state_q == ST_IDLE && i_psel && i_penable && o_pready && i_pwrite
             && i_paddr == `FLQR_REG_CTRL && i_pwdata[2:0] <= `FLQR_OP_QUERY)
    begin
      verify_err_q <= 1'b0;
      upper_err_q  <= 1'b0;
      qry_ok_q     <= i_pwdata[2:0] == `FLQR_OP_QUERY;
    end
    else if (state_q == ST_RELEASE && !o_flash.oe_n)
    begin
      if (op_q == `FLQR_OP_QUERY)
      begin
        if (i_fl_dq[15:8] != 8'h00)
        begin
          upper_err_q <= 1'b1;
        end
        if (int'(q_widx) < 3 && i_fl_dq[7:0] != qry_expect(q_widx))
        begin
          qry_ok_q <= 1'b0;
        end
      end
      else
      begin
        bstat_q <= i_fl_dq[7:0];
        if (i_fl_dq[7:2] != 6'h00)
        begin
          verify_err_q <= 1'b1;
        end
        case (op_q)
          `FLQR_OP_LOCK:
            if (!i_fl_dq[`FLQR_BIT_LOCKED]) verify_err_q <= 1'b1;
          `FLQR_OP_UNLOCK:
            if (i_fl_dq[`FLQR_BIT_LOCKED]) verify_err_q <= 1'b1;
          `FLQR_OP_LOCKDOWN:
            if (!i_fl_dq[`FLQR_BIT_LOCKDOWN]) verify_err_q <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Low lane only; pairs of bytes stay in table order, low byte first
  flqr_qmem #(
    .W (8),
    .D (QLEN),
    .A (QA)
  ) u_qmem (
    .i_clk   (i_clk),
    .i_we    (q_we),
    .i_waddr (q_widx),
    .i_wdata (i_fl_dq[7:0]),
    .i_raddr (q_raddr),
    .o_rdata (q_rdata)
  );

  assign q_raddr = QA'((i_paddr - `FLQR_REG_QDATA) >> 2);

  // Operation and block address registers
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      op_q   <= `FLQR_OP_LOCK;
      base_q <= '0;
    end
    else if (state_q == ST_IDLE && i_psel && i_penable && o_pready && i_pwrite)
    begin
      if (i_paddr == `FLQR_REG_CTRL && i_pwdata[2:0] <= `FLQR_OP_QUERY)
      begin
        op_q <= i_pwdata[2:0];
      end
      if (i_paddr == `FLQR_REG_ADDR)
      begin
        base_q <= i_pwdata[`FLQR_ADDR_W-1:0];
      end
    end
  end

  // APB answer: one wait state so query memory data is ready
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && i_penable && !o_pready)
      begin
        if (i_paddr == `FLQR_REG_CTRL)
        begin
          o_prdata <= {29'h0, op_q};
        end
        else if (i_paddr == `FLQR_REG_ADDR)
        begin
          o_prdata <= 32'(base_q);
        end
        else if (i_paddr == `FLQR_REG_STATUS)
        begin
          o_prdata <= {16'h0, bstat_q, 4'h0, qry_ok_q, upper_err_q, verify_err_q,
                       state_q != ST_IDLE};
        end
        // Range taken on the full address, the cut index would alias
        else if (i_paddr >= `FLQR_REG_QDATA && i_paddr[1:0] == 2'b00
                 && i_paddr < 12'(`FLQR_REG_QDATA + 4 * QLEN))
        begin
          o_prdata <= {24'h0, q_rdata};
        end
        else
        begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== flqr_ctrl_bench.sv
// Purpose: Self-checking run of the lock and query controller over APB
// Assumes: Flash model answers well inside the read strobe
// Notes:   Expected query bytes are kept here, apart from the model
`timescale 1ns/1ps
`include "flqr_cfg.svh"
module flqr_ctrl_bench
  import flqr_pkg::*;
();
  localparam logic [15:0] PRI = 16'h0203; // Arbitrary value
  logic        i_clk, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, bad_upper;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [15:0] fl_dq;
  logic [1:0]  fl_mode;
  logic [7:0]  qexp [0:10];
  flqr_pins_s  fl;
  int          failures, checked;

  flqr_ctrl #(.QLEN(11)) flqr_ctrl_inst (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .o_flash(fl), .i_fl_dq(fl_dq));
  flqr_flash_model #(.PRI_CODE(PRI)) flqr_flash_model_inst (.i_pins(fl),
    .i_bad_upper(bad_upper), .o_dq(fl_dq), .o_mode(fl_mode));

  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] d, output logic er);
    int n;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, o_pready});
    d = o_prdata;
    er = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        er;
    xfer(1'b1, a, v, d, er);
  endtask

  // Second address write lands while busy and must be dropped
  task automatic op(input logic [2:0] c, input logic [21:0] b, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] d;
    logic        er;
    int          n;
    wr(`FLQR_REG_ADDR, {10'h0, b});
    wr(`FLQR_REG_CTRL, {29'h0, c});
    wr(`FLQR_REG_ADDR, 32'h003f0000);
    d = 32'h1;
    n = 0;
    while (d[0] !== 1'b0 && n < 200)
    begin
      xfer(1'b0, `FLQR_REG_STATUS, 32'h0, d, er);
      n++;
    end
    chk("busy", 32'h0, {31'h0, d[0]});
    chk("status", e, d & m);
    chk("flash mode", 32'h0, {30'h0, fl_mode});
    xfer(1'b0, `FLQR_REG_ADDR, 32'h0, d, er);
    chk("addr kept while busy", {10'h0, b}, d);
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever
      #10 i_clk = ~i_clk;
  end

  initial
  begin
    #1000000;
    failures++;
    test_done;
  end

  initial
  begin
    logic [31:0] d;
    logic        er;
    failures  = 0;
    checked   = 0;
    i_nrst    = 1'b0;
    i_psel    = 1'b0;
    i_penable = 1'b0;
    i_pwrite  = 1'b0;
    i_paddr   = 12'h000;
    i_pwdata  = 32'h0;
    bad_upper = 1'b0;
    qexp = '{8'h51, 8'h52, 8'h59, PRI[7:0], PRI[15:8], 8'h35, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    xfer(1'b0, 12'h00c, 32'h0, d, er);
    chk("unmapped data", 32'h0, d);
    chk("unmapped err", 32'h1, {31'h0, er});
    xfer(1'b0, 12'h06c, 32'h0, d, er);
    chk("query range err", 32'h1, {31'h0, er});
    wr(`FLQR_REG_ADDR, 32'hffffffff);
    xfer(1'b0, `FLQR_REG_ADDR, 32'h0, d, er);
    chk("addr width", 32'h003fffff, d);
    op(3'h0, 22'h008000, 32'hff0e, 32'h0100);
    op(3'h3, 22'h010000, 32'hff0e, 32'h0000);
    op(3'h1, 22'h008000, 32'hff0e, 32'h0000);
    op(3'h2, 22'h008000, 32'hff0e, 32'h0300);
    op(3'h1, 22'h008000, 32'hff0e, 32'h0302);
    wr(`FLQR_REG_CTRL, 32'h5);
    xfer(1'b0, `FLQR_REG_CTRL, 32'h0, d, er);
    chk("bad op ignored", 32'h1, d & 32'h7);
    xfer(1'b0, `FLQR_REG_STATUS, 32'h0, d, er);
    chk("bad op keeps status", 32'h0302, d & 32'hff0e);
    op(3'h4, 22'h0, 32'h000e, 32'h0008);
    for (int i = 0; i < 11; i++)
    begin
      xfer(1'b0, 12'h040 + 12'(4 * i), 32'h0, d, er);
      chk("query byte", {24'h0, qexp[i]}, d);
    end
    bad_upper <= 1'b1;
    op(3'h4, 22'h0, 32'h0004, 32'h0004);
    bad_upper <= 1'b0;
    op(3'h3, 22'h008000, 32'hff0e, 32'h0300);
    // Mid-run reset must clear results and the block address
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    xfer(1'b0, `FLQR_REG_STATUS, 32'h0, d, er);
    chk("status after reset", 32'h0, d);
    xfer(1'b0, `FLQR_REG_ADDR, 32'h0, d, er);
    chk("addr after reset", 32'h0, d);
    test_done;
  end
endmodule

// ===== flqr_ctrl_sva.sv
// Purpose: Port-level protocol checks for the lock and query controller
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by bind, sees ports only
`timescale 1ns/1ps
module flqr_ctrl_sva
  import flqr_pkg::*;
#(
  parameter int QLEN = 11
) (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_nrst,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  // Flash pins
  input wire flqr_pins_s  o_flash
);
  logic [7:0] last_cmd_q;
  logic       rd_seen_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Last command word and whether a read came after it
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      last_cmd_q <= 8'hff;
    else if ($fell(o_flash.we_n))
      last_cmd_q <= o_flash.dq[7:0];
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      rd_seen_q <= 1'b0;
    else if ($fell(o_flash.oe_n))
      rd_seen_q <= 1'b1;
    else if ($fell(o_flash.we_n))
      rd_seen_q <= 1'b0;
  end
  rdy_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready held more than one cycle");
  rdy_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready not one cycle after access");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data nonzero outside ready");
  setup_first_a: assert property ($fell(o_flash.we_n) && o_flash.dq[7:0] inside
    {8'h01, 8'hd0, 8'h2f} |-> last_cmd_q == 8'h60)
    else $error("confirm code without setup");
  confirm_next_a: assert property ($fell(o_flash.we_n) && last_cmd_q == 8'h60
    |-> o_flash.dq[7:0] inside {8'h01, 8'hd0, 8'h2f})
    else $error("setup not followed by confirm");
  cfg_read_a: assert property ($fell(o_flash.oe_n)
    |-> last_cmd_q inside {8'h90, 8'h98})
    else $error("flash read outside status or query mode");
  ff_close_a: assert property ($fell(o_flash.we_n) && rd_seen_q
    |-> o_flash.dq[7:0] == 8'hff)
    else $error("sequence not closed by read array");
  we_width_a: assert property ($fell(o_flash.we_n) |-> !o_flash.we_n [*3])
    else $error("write strobe too short");
  oe_width_a: assert property ($fell(o_flash.oe_n) |-> !o_flash.oe_n [*4])
    else $error("read strobe too short");
  no_clash_a: assert property (!o_flash.oe_n |-> !o_flash.dq_oe)
    else $error("data driven during flash read");
endmodule

bind flqr_ctrl flqr_ctrl_sva #(.QLEN(QLEN)) flqr_ctrl_sva_inst (.i_clk, .i_nrst, .i_psel,
  .i_penable, .o_pready, .o_prdata, .o_flash);

// ===== flqr_flash_model.sv
// Purpose: Behavioural x16 flash with block locks and query table
// Assumes: Commands taken on falling write strobe with chip enable low
// Notes:   Released bus shows the inverted word, never a held value
`timescale 1ns/1ps
module flqr_flash_model
  import flqr_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h005a, // Arbitrary value
  parameter logic [15:0] PRI_CODE = 16'h0203, // Arbitrary value
  parameter logic [15:0] EXT_PTR  = 16'h0035
) (
  // Flash pins
  input  wire flqr_pins_s  i_pins,
  // Fault injection
  input  wire logic        i_bad_upper,
  // Data and mode
  output logic      [15:0] o_dq,
  output logic      [1:0]  o_mode
);
  logic [1:0]  lock_q [0:127];
  logic [15:0] val;
  logic [14:0] off;
  logic [6:0]  blk;
  logic [7:0]  cmd;
  assign off = i_pins.addr[14:0];
  assign blk = i_pins.addr[21:15];
  assign cmd = i_pins.dq[7:0];
  initial
  begin
    o_mode = 2'd0;
    foreach (lock_q[i])
      lock_q[i] = 2'b00;
  end
  // Mode ignores the address, as setup does
  always @(negedge i_pins.we_n)
  begin
    if (!i_pins.ce_n && o_mode == 2'd1)
    begin
      if (cmd == 8'h01)
        lock_q[blk][0] = 1'b1;
      if (cmd == 8'hd0 && !lock_q[blk][1])
        lock_q[blk][0] = 1'b0;
      if (cmd == 8'h2f)
        lock_q[blk] = 2'b11;
      o_mode = 2'd0;
    end
    else if (!i_pins.ce_n)
      o_mode = (cmd == 8'h60) ? 2'd1 : (cmd == 8'h90) ? 2'd2 :
        (cmd == 8'h98) ? 2'd3 : 2'd0;
  end
  function automatic logic [7:0] qb(input logic [14:0] a);
    case (a)
      15'h10: return 8'h51;
      15'h11: return 8'h52;
      15'h12: return 8'h59;
      15'h13: return PRI_CODE[7:0];
      15'h14: return PRI_CODE[15:8];
      15'h15: return EXT_PTR[7:0];
      15'h16: return EXT_PTR[15:8];
      default: return 8'h00;
    endcase
  endfunction
  always_comb
  begin
    val = {1'b0, off};
    if (o_mode[1])
      val = (off == 15'h0) ? MFR_CODE : (off == 15'h1) ? DEV_CODE :
        (off == 15'h2) ? {14'h0, lock_q[blk]} : 16'h0;
    if (o_mode == 2'd3 && off >= 15'h10)
      val = {i_bad_upper ? 8'h80 : 8'h00, qb(off)};
  end
  assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? val : ~val;
endmodule

// ===== flqr_pkg.sv
// Purpose: Types for the flash lock and query readout controller
// Assumes: flqr_cfg.svh supplies the widths
// Notes:   Pin bundle travels as one packed struct
`include "flqr_cfg.svh"

package flqr_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RELEASE
  } flqr_state_e;

  typedef struct packed
  {
    logic [`FLQR_ADDR_W-1:0] addr;
    logic [15:0]             dq;
    logic                    dq_oe;
    logic                    ce_n;
    logic                    we_n;
    logic                    oe_n;
  } flqr_pins_s;

endpackage

// ===== flqr_qmem.sv
// Purpose: Small store for captured query bytes
// Assumes: One write port, one read port, same clock
// Notes:   Read data is registered, one cycle behind the address
`timescale 1ns/1ps

module flqr_qmem #(
  parameter int W = 8,
  parameter int D = 11,
  parameter int A = 4
) (
  // Clock
  input  wire logic         i_clk,
  // Write port
  input  wire logic         i_we,
  input  wire logic [A-1:0] i_waddr,
  input  wire logic [W-1:0] i_wdata,
  // Read port
  input  wire logic [A-1:0] i_raddr,
  output logic      [W-1:0] o_rdata
);

  logic [W-1:0] mem_q [D];

  always_ff @(posedge i_clk)
  begin
    if (i_we && (int'(i_waddr) < D))
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // Out-of-range reads give zero rather than stale data
  always_ff @(posedge i_clk)
  begin
    if (int'(i_raddr) < D)
    begin
      o_rdata <= mem_q[i_raddr];
    end
    else
    begin
      o_rdata <= '0;
    end
  end

endmodule
